/* src/slink_test_pkg.sv */
// shared constants, register map and helpers for the link self-test logic
package slink_test_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int lanes = 8;
  localparam int channels = 4;
  localparam int samples_per_channel = 3;
  localparam int count_w = 24;
  localparam int hist_w = 31;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] addr_lane_enable = 12'h315;
  localparam logic [11:0] addr_prbs_control = 12'h316;
  localparam logic [11:0] addr_prbs_threshold_low = 12'h317;
  localparam logic [11:0] addr_prbs_threshold_mid = 12'h318;
  localparam logic [11:0] addr_prbs_threshold_high = 12'h319;
  localparam logic [11:0] addr_prbs_error_count_low = 12'h31a;
  localparam logic [11:0] addr_prbs_error_count_mid = 12'h31b;
  localparam logic [11:0] addr_prbs_error_count_high = 12'h31c;
  localparam logic [11:0] addr_prbs_lane_pass_flags = 12'h31d;
  localparam logic [11:0] addr_sample_check_control = 12'h32c;
  localparam logic [11:0] addr_sample_check_reference_low = 12'h32d;
  localparam logic [11:0] addr_sample_check_reference_high = 12'h32e;
  localparam logic [11:0] addr_sample_check_result = 12'h32f;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int test_clear_bit = 0;
  localparam int test_run_bit = 1;
  localparam int poly_lsb = 2;
  localparam int lane_sel_lsb = 4;
  localparam int check_enable_bit = 0;
  localparam int check_clear_bit = 1;
  localparam int channel_sel_lsb = 2;
  localparam int sample_sel_lsb = 4;
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [7:0] pass_reset = 8'hff;
  localparam logic [count_w-1:0] count_max = 24'hffffff;
  // ----------------------------------------------------------------
  // polynomial and sample codes
  // ----------------------------------------------------------------
  localparam logic [1:0] poly_prbs7 = 2'h0;
  localparam logic [1:0] poly_prbs15 = 2'h1;
  localparam logic [1:0] poly_prbs31 = 2'h2;
  localparam logic [1:0] poly_unused = 2'h3;
  localparam logic [1:0] sample_unused = 2'h3;

  // expected next bit from the received history, self-synchronising
  function automatic logic prbs_predict(input logic [hist_w-1:0] hist, input logic [1:0] sel);
    case (sel)
      poly_prbs7: prbs_predict = hist[6] ^ hist[5];
      poly_prbs15: prbs_predict = hist[14] ^ hist[13];
      default: prbs_predict = hist[30] ^ hist[27];
    endcase
  endfunction

  // bits needed to seed the history before any comparison is trusted
  function automatic logic [4:0] prbs_order(input logic [1:0] sel);
    case (sel)
      poly_prbs7: prbs_order = 5'h07;
      poly_prbs15: prbs_order = 5'h0f;
      default: prbs_order = 5'h1f;
    endcase
  endfunction
endpackage

/* src/lane_err_if.sv */
// control and result bundle between the register block and one lane checker
`timescale 1ns/1ps
interface lane_err_if;
  import slink_test_pkg::*;
  logic run;
  logic clear;
  logic [1:0] poly_sel;
  logic [count_w-1:0] threshold;
  logic [count_w-1:0] err_count;
  logic pass;
  modport ctrl (output run, output clear, output poly_sel, output threshold,
                input err_count, input pass);
  modport chk (input run, input clear, input poly_sel, input threshold,
               output err_count, output pass);
endinterface

/* src/prbs_lane_checker.sv */
// per-lane prbs bit error checker with saturating counter and pass flag
`timescale 1ns/1ps
module prbs_lane_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic lane_bit,
  input wire logic lane_valid,
  lane_err_if.chk link
);
  import slink_test_pkg::*;
  typedef enum logic [1:0] {idle, fill, check} lane_state_t;
  lane_state_t state;
  logic [hist_w-1:0] hist;
  logic [4:0] seeded;

  // ----------------------------------------------------------------
  // sequencing and counting
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || link.clear) begin
      state <= idle;
      hist <= '0;
      seeded <= '0;
      link.err_count <= '0;
    end else begin
      case (state)
        idle: begin
          // unused polynomial code keeps the lane idle
          if (link.run && link.poly_sel != poly_unused) begin
            state <= fill;
            seeded <= '0;
          end
        end
        fill: begin
          if (!link.run) begin
            state <= idle;
          end else if (lane_valid) begin
            hist <= {hist[hist_w-2:0], lane_bit};
            seeded <= seeded + 5'h01;
            if (seeded == prbs_order(link.poly_sel) - 5'h01) begin
              state <= check;
            end
          end
        end
        check: begin
          if (!link.run) begin
            state <= idle;
          end else if (lane_valid) begin
            hist <= {hist[hist_w-2:0], lane_bit};
            if (lane_bit != prbs_predict(hist, link.poly_sel)
                && link.err_count != count_max) begin
              link.err_count <= link.err_count + 24'h000001;
            end
          end
        end
        default: state <= idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pass flag: a failing count wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link.pass <= 1'b1;
    end else if (link.err_count > link.threshold) begin
      link.pass <= 1'b0;
    end else if (link.clear) begin
      link.pass <= 1'b1;
    end
  end

  clear_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
    link.clear |=> link.err_count == '0)
    else $error("lane count not cleared");
endmodule

/* src/sample_checker.sv */
// transport-layer check of one received sample against a reference
`timescale 1ns/1ps
module sample_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic clear,
  input wire logic [1:0] channel_sel,
  input wire logic [1:0] sample_sel,
  input wire logic [15:0] reference,
  input wire logic [slink_test_pkg::channels-1:0][slink_test_pkg::samples_per_channel-1:0][15:0] samples,
  input wire logic sample_valid,
  output logic mismatch
);
  import slink_test_pkg::*;
  logic [15:0] picked;
  logic differ;

  // ----------------------------------------------------------------
  // selection and compare
  // ----------------------------------------------------------------
  always_comb begin
    picked = '0;
    if (sample_sel != sample_unused) begin
      picked = samples[channel_sel][sample_sel];
    end
  end

  // the unused sample code never compares, so it cannot report a fail
  assign differ = enable && sample_valid && sample_sel != sample_unused
                  && picked != reference;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mismatch <= 1'b0;
    end else if (differ) begin
      mismatch <= 1'b1;
    end else if (clear) begin
      mismatch <= 1'b0;
    end
  end

  disabled_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
    !enable |=> !$rose(mismatch))
    else $error("result rose while check disabled");
  result_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    mismatch && !clear |=> mismatch)
    else $error("mismatch result not latched");
  clear_result_a: assert property (@(posedge clock) disable iff (sys_rst)
    clear && !differ |=> !mismatch)
    else $error("result not cleared");
endmodule

/* src/serial_link_prbs_and_sample_checker.sv */
// register block and top of the link prbs and sample self-test logic
`timescale 1ns/1ps
// Function
// - select prbs7, prbs15 or prbs31 by field
// - prbs test runs only while run bit set
// - clear bit resets lane sequencers and counters
// - 24-bit threshold from three writable bytes
// - selected lane count readable as three bytes
// - per-lane pass bits, all pass after reset
// - sample selector picks sample 0 to 2
// - channel selector picks converter 0 to 3
// - sample clear bit clears stored result
// - sample compare only while enable set
// - 16-bit reference held in two bytes
// - compare reference with selected received sample
// - per-lane enable mask gates the prbs test
// - 3-bit lane select picks reported count
// - result bit 0 on match, 1 from a mismatch until the sample clear bit clears it
module serial_link_prbs_and_sample_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic [slink_test_pkg::lanes-1:0] lane_bits,
  input wire logic [slink_test_pkg::lanes-1:0] lane_valid,
  input wire logic [slink_test_pkg::channels-1:0][slink_test_pkg::samples_per_channel-1:0][15:0] converter_samples,
  input wire logic sample_valid,
  output logic [slink_test_pkg::lanes-1:0] lane_pass_flags,
  output logic sample_mismatch_flag
);
  import slink_test_pkg::*;

  // ----------------------------------------------------------------
  // software state
  // ----------------------------------------------------------------
  logic [lanes-1:0] lane_test_enable_mask;
  logic [2:0] error_count_lane_select;
  logic [1:0] prbs_polynomial_select;
  logic bit_error_test_run;
  logic bit_error_test_clear;
  logic [7:0] error_threshold_low_byte;
  logic [7:0] error_threshold_mid_byte;
  logic [7:0] error_threshold_high_byte;
  logic [1:0] checked_sample_select;
  logic [1:0] checked_channel_select;
  logic sample_check_clear;
  logic sample_check_enable;
  logic [7:0] reference_sample_low;
  logic [7:0] reference_sample_high;
  logic [count_w-1:0] threshold;
  logic [count_w-1:0] count_vec [lanes];
  logic [lanes-1:0] pass_vec;
  logic [count_w-1:0] selected_count;
  logic sample_check_result;
  logic [7:0] next_rdata;

  function automatic logic write_to(input logic [11:0] addr, input logic [11:0] target);
    write_to = addr == target;
  endfunction

  assign threshold = {error_threshold_high_byte, error_threshold_mid_byte,
                      error_threshold_low_byte};
  assign selected_count = count_vec[error_count_lane_select];

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lane_test_enable_mask <= byte_reset[lanes-1:0];
    end else if (reg_write && write_to(reg_addr, addr_lane_enable)) begin
      lane_test_enable_mask <= reg_wdata[lanes-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      error_count_lane_select <= '0;
      prbs_polynomial_select <= poly_prbs7;
      bit_error_test_run <= 1'b0;
      bit_error_test_clear <= 1'b0;
    end else if (reg_write && write_to(reg_addr, addr_prbs_control)) begin
      error_count_lane_select <= reg_wdata[lane_sel_lsb +: 3];
      prbs_polynomial_select <= reg_wdata[poly_lsb +: 2];
      bit_error_test_run <= reg_wdata[test_run_bit];
      bit_error_test_clear <= reg_wdata[test_clear_bit];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      error_threshold_low_byte <= byte_reset;
      error_threshold_mid_byte <= byte_reset;
      error_threshold_high_byte <= byte_reset;
    end else if (reg_write) begin
      if (write_to(reg_addr, addr_prbs_threshold_low)) begin
        error_threshold_low_byte <= reg_wdata;
      end
      if (write_to(reg_addr, addr_prbs_threshold_mid)) begin
        error_threshold_mid_byte <= reg_wdata;
      end
      if (write_to(reg_addr, addr_prbs_threshold_high)) begin
        error_threshold_high_byte <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      checked_sample_select <= '0;
      checked_channel_select <= '0;
      sample_check_clear <= 1'b0;
      sample_check_enable <= 1'b0;
    end else if (reg_write && write_to(reg_addr, addr_sample_check_control)) begin
      checked_sample_select <= reg_wdata[sample_sel_lsb +: 2];
      checked_channel_select <= reg_wdata[channel_sel_lsb +: 2];
      sample_check_clear <= reg_wdata[check_clear_bit];
      sample_check_enable <= reg_wdata[check_enable_bit];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reference_sample_low <= byte_reset;
      reference_sample_high <= byte_reset;
    end else if (reg_write) begin
      if (write_to(reg_addr, addr_sample_check_reference_low)) begin
        reference_sample_low <= reg_wdata;
      end
      if (write_to(reg_addr, addr_sample_check_reference_high)) begin
        reference_sample_high <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // readback; unmapped and reserved bits read as zero
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = byte_reset;
    case (reg_addr)
      addr_lane_enable: next_rdata = lane_test_enable_mask;
      addr_prbs_control: next_rdata = {1'b0, error_count_lane_select, prbs_polynomial_select,
                                       bit_error_test_run, bit_error_test_clear};
      addr_prbs_threshold_low: next_rdata = error_threshold_low_byte;
      addr_prbs_threshold_mid: next_rdata = error_threshold_mid_byte;
      addr_prbs_threshold_high: next_rdata = error_threshold_high_byte;
      addr_prbs_error_count_low: next_rdata = selected_count[7:0];
      addr_prbs_error_count_mid: next_rdata = selected_count[15:8];
      addr_prbs_error_count_high: next_rdata = selected_count[23:16];
      addr_prbs_lane_pass_flags: next_rdata = pass_vec;
      addr_sample_check_control: next_rdata = {2'h0, checked_sample_select,
                                               checked_channel_select,
                                               sample_check_clear, sample_check_enable};
      addr_sample_check_reference_low: next_rdata = reference_sample_low;
      addr_sample_check_reference_high: next_rdata = reference_sample_high;
      addr_sample_check_result: next_rdata = {7'h00, sample_check_result};
      default: next_rdata = byte_reset;
    endcase
  end

  // counts are live; a three-byte read is not frozen, so stop the test first
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= byte_reset;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_read;
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lane_pass_flags <= pass_reset;
      sample_mismatch_flag <= 1'b0;
    end else begin
      lane_pass_flags <= pass_vec;
      sample_mismatch_flag <= sample_check_result;
    end
  end

  // ----------------------------------------------------------------
  // lane checkers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < lanes; g++) begin : lane
    lane_err_if link ();
    assign link.run = bit_error_test_run && lane_test_enable_mask[g];
    assign link.clear = bit_error_test_clear;
    assign link.poly_sel = prbs_polynomial_select;
    assign link.threshold = threshold;
    assign count_vec[g] = link.err_count;
    assign pass_vec[g] = link.pass;
    // relies on the transmitter sending the chosen sequence on each lane
    prbs_lane_checker lane_check (
      .clock(clock),
      .sys_rst(sys_rst),
      .lane_bit(lane_bits[g]),
      .lane_valid(lane_valid[g]),
      .link(link)
    );
  end

  // ----------------------------------------------------------------
  // transport-layer sample check
  // ----------------------------------------------------------------
  sample_checker sampler (
    .clock(clock),
    .sys_rst(sys_rst),
    .enable(sample_check_enable),
    .clear(sample_check_clear),
    .channel_sel(checked_channel_select),
    .sample_sel(checked_sample_select),
    .reference({reference_sample_high, reference_sample_low}),
    .samples(converter_samples),
    .sample_valid(sample_valid),
    .mismatch(sample_check_result)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence ctrl_write;
    reg_write && reg_addr == addr_prbs_control;
  endsequence

  sequence count_low_read;
    reg_read && reg_addr == addr_prbs_error_count_low;
  endsequence

  sequence check_ctrl_write;
    reg_write && reg_addr == addr_sample_check_control;
  endsequence

  sequence mask_write;
    reg_write && reg_addr == addr_lane_enable;
  endsequence

  sequence flags_read;
    reg_read && reg_addr == addr_prbs_lane_pass_flags;
  endsequence

  sequence ref_low_write;
    reg_write && reg_addr == addr_sample_check_reference_low;
  endsequence

  sequence lane0_masked;
    (!lane_test_enable_mask[0] && !bit_error_test_clear) [*2];
  endsequence

  poly_field_a: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_write |=> prbs_polynomial_select == $past(reg_wdata[poly_lsb +: 2]))
    else $error("polynomial field not stored");

  stopped_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!bit_error_test_run && !bit_error_test_clear) [*2] |-> $stable(count_vec[1]))
    else $error("count moved while stopped");

  clear_all_a: assert property (@(posedge clock) disable iff (sys_rst)
    bit_error_test_clear |=> count_vec[lanes-1] == '0 && count_vec[0] == '0)
    else $error("counts not cleared");

  threshold_mid_a: assert property (@(posedge clock) disable iff (sys_rst)
    reg_write && reg_addr == addr_prbs_threshold_mid |=> threshold[15:8] == $past(reg_wdata))
    else $error("threshold mid byte not stored");

  count_read_a: assert property (@(posedge clock) disable iff (sys_rst)
    count_low_read |=> reg_rdata_valid && reg_rdata == $past(selected_count[7:0]))
    else $error("count low byte readback wrong");

  pass_reset_a: assert property (@(posedge clock)
    sys_rst |=> lane_pass_flags == pass_reset)
    else $error("pass flags not all set after reset");

  pass_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(pass_vec[1]) |-> $past(count_vec[1] > threshold))
    else $error("pass dropped without threshold crossing");

  ref_high_a: assert property (@(posedge clock) disable iff (sys_rst)
    reg_write && reg_addr == addr_sample_check_reference_high
    |=> reference_sample_high == $past(reg_wdata))
    else $error("reference high byte not stored");

  result_read_a: assert property (@(posedge clock) disable iff (sys_rst)
    reg_read && reg_addr == addr_sample_check_result
    |=> reg_rdata == {7'h00, $past(sample_check_result)})
    else $error("result readback wrong");

  lane_sel_a: assert property (@(posedge clock) disable iff (sys_rst)
    ctrl_write
    |=> error_count_lane_select == $past(reg_wdata[lane_sel_lsb +: 3]))
    else $error("lane select not stored");

  sample_sel_a: assert property (@(posedge clock) disable iff (sys_rst)
    check_ctrl_write
    |=> checked_sample_select == $past(reg_wdata[sample_sel_lsb +: 2]))
    else $error("sample select not stored");

  channel_sel_a: assert property (@(posedge clock) disable iff (sys_rst)
    check_ctrl_write
    |=> checked_channel_select == $past(reg_wdata[channel_sel_lsb +: 2]))
    else $error("channel select not stored");

  check_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    check_ctrl_write
    |=> sample_check_clear == $past(reg_wdata[check_clear_bit]))
    else $error("sample clear bit not stored");

  check_enable_a: assert property (@(posedge clock) disable iff (sys_rst)
    check_ctrl_write
    |=> sample_check_enable == $past(reg_wdata[check_enable_bit]))
    else $error("sample enable bit not stored");

  mask_store_a: assert property (@(posedge clock) disable iff (sys_rst)
    mask_write
    |=> lane_test_enable_mask == $past(reg_wdata[lanes-1:0]))
    else $error("lane mask not stored");

  masked_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    lane0_masked
    |-> $stable(count_vec[0]))
    else $error("masked lane count moved");

  flags_read_a: assert property (@(posedge clock) disable iff (sys_rst)
    flags_read
    |=> reg_rdata == $past(pass_vec))
    else $error("pass flags readback wrong");

  flags_copy_a: assert property (@(posedge clock) disable iff (sys_rst)
    1'b1
    |=> lane_pass_flags == $past(pass_vec))
    else $error("pass flag output not a copy");

  ref_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    ref_low_write
    |=> reference_sample_low == $past(reg_wdata))
    else $error("reference low byte not stored");
endmodule

/* sim/link_tx_model.sv */
// transmitter model sending prbs bits and known samples
`timescale 1ns/1ps
module link_tx_model (
  input wire logic clock,
  input wire logic [1:0] poly,
  input wire logic [slink_test_pkg::lanes-1:0] flip,
  output logic [slink_test_pkg::lanes-1:0] lane_bits,
  output logic [slink_test_pkg::lanes-1:0] lane_valid,
  output logic [slink_test_pkg::channels-1:0][slink_test_pkg::samples_per_channel-1:0][15:0] samples,
  output logic sample_valid
);
  import slink_test_pkg::*;
  // ----------
  // prbs source
  // ----------
  logic [30:0] hist = 31'h00004d2b;
  logic fb;
  always_comb begin
    case (poly)
      2'h1: fb = hist[14] ^ hist[13];
      2'h2: fb = hist[30] ^ hist[27];
      default: fb = hist[6] ^ hist[5];
    endcase
  end
  always @(negedge clock) begin
    hist <= {hist[29:0], fb};
  end
  // same sequence on all lanes; flip injects single bit errors
  assign lane_bits = {lanes{hist[0]}} ^ flip;
  initial begin
    lane_valid = '1;
    sample_valid = 1'b1;
    for (int c = 0; c < channels; c++) begin
      for (int s = 0; s < samples_per_channel; s++) begin
        samples[c][s] = 16'hc300 + 16'(c * 16 + s);
      end
    end
  end
endmodule

/* sim/test_serial_link_prbs_and_sample_checker.sv */
// self-checking bench for the link prbs and sample self-test logic
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module test_serial_link_prbs_and_sample_checker;
  import slink_test_pkg::*;
  // ----------
  // signals
  // ----------
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rdata_valid;
  logic [lanes-1:0] lane_bits;
  logic [lanes-1:0] lane_valid;
  logic [lanes-1:0] lane_pass_flags;
  logic [lanes-1:0] flip = 8'h00;
  logic [1:0] tx_poly = 2'h0;
  logic [channels-1:0][samples_per_channel-1:0][15:0] converter_samples;
  logic sample_valid;
  logic sample_mismatch_flag;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  serial_link_prbs_and_sample_checker i_dut (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .lane_bits(lane_bits),
    .lane_valid(lane_valid), .converter_samples(converter_samples),
    .sample_valid(sample_valid), .lane_pass_flags(lane_pass_flags),
    .sample_mismatch_flag(sample_mismatch_flag));
  link_tx_model i_tx (.clock(clock), .poly(tx_poly), .flip(flip), .lane_bits(lane_bits),
    .lane_valid(lane_valid), .samples(converter_samples), .sample_valid(sample_valid));
  initial begin
    forever #4 clock = ~clock;
  end
  // the run needs about 1100 cycles; the ceiling leaves ample margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // ----------
  // register port tasks
  // ----------
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    `CHK(reg_rdata_valid, 1'b1)
    `CHK(reg_rdata, e)
  endtask
  task automatic pulse_err(input logic [7:0] m);
    flip = m;
    @(negedge clock);
    flip = 8'h00;
    repeat (40) @(negedge clock);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------
  // tests
  // ----------
  initial begin
    logic [2:0] l;
    logic [7:0] cnt;
    logic [15:0] r;
    int thr;
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    for (int i = 0; i < 7; i++) rd_chk(12'h317 + 12'(i), (i == 6) ? pass_reset : 8'h00);
    for (int i = 0; i < 4; i++) rd_chk(12'h32c + 12'(i), 8'h00);
    rd_chk(12'h300, 8'h00);
    `CHK(lane_pass_flags, pass_reset)
    for (int i = 0; i < 3; i++) wr(12'h317 + 12'(i), 8'h5a ^ 8'(i * 17));
    for (int i = 0; i < 3; i++) rd_chk(12'h317 + 12'(i), 8'h5a ^ 8'(i * 17));
    wr(addr_prbs_lane_pass_flags, 8'h00);
    rd_chk(addr_prbs_lane_pass_flags, pass_reset);
    wr(addr_prbs_error_count_low, 8'h55);
    rd_chk(addr_prbs_error_count_low, 8'h00);
    $display("test registers done");
    for (int i = 1; i < 3; i++) wr(12'h317 + 12'(i), 8'h00);
    // lane 0 masked off but still given errors; code 3 must count nothing
    wr(addr_lane_enable, 8'hfe);
    for (int p = 0; p < 4; p++) begin
      l = 3'(2 * p + 1);
      thr = (p == 1) ? 3 : 2;
      cnt = (p == 3) ? 8'h00 : 8'h03;
      tx_poly <= 2'(p);
      wr(addr_prbs_threshold_low, 8'(thr));
      wr(addr_prbs_control, {1'b0, l, 2'(p), 2'b01});
      wr(addr_prbs_control, {1'b0, l, 2'(p), 2'b10});
      repeat (100) @(negedge clock);
      pulse_err(8'h01 | (8'h01 << l));
      rd_chk(addr_prbs_error_count_low, cnt);
      rd_chk(addr_prbs_error_count_mid, 8'h00);
      rd_chk(addr_prbs_error_count_high, 8'h00);
      `CHK(lane_pass_flags, (p != 3 && thr < 3) ? ~(8'h01 << l) : 8'hff)
      wr(addr_prbs_control, {1'b0, 3'h0, 2'(p), 2'b10});
      rd_chk(addr_prbs_error_count_low, 8'h00);
      wr(addr_prbs_control, {1'b0, l, 2'(p), 2'b00});
      pulse_err(8'h01 << l);
      rd_chk(addr_prbs_error_count_low, cnt);
      wr(addr_prbs_control, {1'b0, l, 2'(p), 2'b01});
      rd_chk(addr_prbs_error_count_low, 8'h00);
      repeat (2) @(negedge clock);
      `CHK(lane_pass_flags, pass_reset)
    end
    $display("test prbs done");
    for (int c = 0; c < channels; c++) begin
      for (int s = 0; s < samples_per_channel; s++) begin
        r = 16'hc300 + 16'(c * 16 + s);
        wr(addr_sample_check_control, 8'h00);
        wr(addr_sample_check_reference_low, r[7:0]);
        wr(addr_sample_check_reference_high, r[15:8]);
        wr(addr_sample_check_control, {2'b00, 2'(s), 2'(c), 2'b01});
        repeat (3) @(negedge clock);
        rd_chk(addr_sample_check_control, {2'b00, 2'(s), 2'(c), 2'b01});
        rd_chk(addr_sample_check_result, 8'h00);
      end
    end
    wr(addr_sample_check_reference_high, r[15:8] ^ 8'h80);
    repeat (3) @(negedge clock);
    rd_chk(addr_sample_check_result, 8'h01);
    `CHK(sample_mismatch_flag, 1'b1)
    wr(addr_sample_check_reference_high, r[15:8]);
    repeat (3) @(negedge clock);
    rd_chk(addr_sample_check_result, 8'h01);
    wr(addr_sample_check_control, 8'h02);
    wr(addr_sample_check_control, 8'h00);
    repeat (3) @(negedge clock);
    rd_chk(addr_sample_check_result, 8'h00);
    `CHK(sample_mismatch_flag, 1'b0)
    wr(addr_sample_check_reference_high, r[15:8] ^ 8'h80);
    wr(addr_sample_check_control, 8'h3d);
    wr(addr_sample_check_control, 8'h2c);
    rd_chk(addr_sample_check_result, 8'h00);
    $display("test sample done");
    print_verdict();
  end
endmodule
